// ---- sbstap_pkg.sv ----
package sbstap_pkg;

    // scan register widths, same for both organisations
    localparam int IR_W = 3;
    localparam int BYP_W = 1;
    localparam int ID_W = 32;

    // boundary chain lengths, selected by organisation (0 = x18, 1 = x36)
    localparam int BSR_LEN_X18 = 51;
    localparam int BSR_LEN_X36 = 70;

    // instruction codes
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDCODE = 3'h1;
    localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [2:0] INS_RSV_3 = 3'h3;
    localparam logic [2:0] INS_SAMPLE = 3'h4;
    localparam logic [2:0] INS_RSV_5 = 3'h5;
    localparam logic [2:0] INS_RSV_6 = 3'h6;
    localparam logic [2:0] INS_BYPASS = 3'h7;

    // value loaded into the instruction shifter in capture-ir
    localparam logic [2:0] IR_CAPTURE = 3'h1;

    // identification register field positions and codes
    localparam int ID_PRESENT_BIT = 0;
    localparam int ID_VEND_LSB = 1;
    localparam int ID_DEV_LSB = 12;
    localparam int ID_WIDTH_LSB = 18;
    localparam int ID_DEPTH_LSB = 23;
    localparam int ID_REV_LSB = 28;
    localparam logic [4:0] ID_DEPTH_CODE [2] = '{5'h08, 5'h07};
    localparam logic [4:0] ID_WIDTH_CODE [2] = '{5'h03, 5'h04};

    // pin groups observed by the boundary chain
    localparam int LANE_W = 9;
    localparam int DQ_N = 36;
    localparam int ADDR_HI_N = 18;
    localparam int CTL_N = 16;

    // control cell order in the control vector
    localparam int CTL_SLEEP = 0;
    localparam int CTL_ADV = 1;
    localparam int CTL_CPU_ADDR_STROBE_IN = 2;
    localparam int CTL_CTRL_ADDR_STROBE_IN = 3;
    localparam int CTL_OE = 4;
    localparam int CTL_BWE = 5;
    localparam int CTL_GW = 6;
    localparam int CTL_CLK = 7;
    localparam int CTL_BWA = 8;
    localparam int CTL_BWB = 9;
    localparam int CTL_BWC = 10;
    localparam int CTL_BWD = 11;
    localparam int CTL_CE = 12;
    localparam int CTL_MODE = 13;
    localparam int CTL_A1 = 14;
    localparam int CTL_A0 = 15;

    // chain cell numbers (1-based, 0 = no cell), [organisation][entry]
    localparam int CTL_CELLS [2][CTL_N] = '{
        '{12, 21, 22, 23, 24, 25, 26, 27, 29, 30, 0, 0, 32, 45, 50, 51},
        '{17, 29, 30, 31, 32, 33, 34, 35, 37, 38, 39, 40, 42, 64, 69, 70}};
    localparam int ADDR_CELLS [2][ADDR_HI_N] = '{
        '{1, 2, 3, 4, 5, 6, 7, 18, 19, 20, 28, 31, 33, 34, 46, 47, 48, 49},
        '{1, 2, 3, 4, 5, 6, 7, 27, 28, 36, 41, 43, 44, 65, 66, 67, 68, 0}};
    localparam int DQ_CELLS [2][DQ_N] = '{
        '{8, 9, 10, 11, 13, 14, 15, 16, 17, 35, 36, 37, 38, 40, 41, 42, 43, 44,
          0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0},
        '{8, 9, 10, 11, 12, 13, 14, 15, 16, 18, 19, 20, 21, 22, 23, 24, 25, 26,
          45, 46, 47, 48, 49, 50, 51, 52, 53, 55, 56, 57, 58, 59, 60, 61, 62, 63}};

    typedef enum logic [3:0] {
        ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR,
        ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
        ST_PA_IR, ST_EX2_IR, ST_UPD_IR
    } sbstap_state_t;

endpackage

// ---- sbstap_fsm.sv ----
`timescale 1ns/1ps
module sbstap_fsm
    import sbstap_pkg::*;
(
    input wire logic tck_i,
    input wire logic tap_rstn_i,
    input wire logic tms_i,
    output sbstap_state_t state_o
);

    sbstap_state_t state_r;
    sbstap_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_TLR: state_nxt = tms_i ? ST_TLR : ST_RTI;
            ST_RTI: state_nxt = tms_i ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: state_nxt = tms_i ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_nxt = tms_i ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_nxt = tms_i ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_nxt = tms_i ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR: state_nxt = tms_i ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: state_nxt = tms_i ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_nxt = tms_i ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: state_nxt = tms_i ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: state_nxt = tms_i ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: state_nxt = tms_i ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_nxt = tms_i ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR: state_nxt = tms_i ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: state_nxt = tms_i ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_nxt = tms_i ? ST_SEL_DR : ST_RTI;
        endcase
    end

    // tms is launched by the controller against tck, so no synchroniser
    always_ff @(posedge tck_i) begin
        if (!tap_rstn_i) begin
            state_r <= ST_TLR;
        end else begin
            state_r <= state_nxt; // R13
        end
    end

    assign state_o = state_r;

endmodule

// ---- sbstap_top.sv ----
`timescale 1ns/1ps
// Functional notes
// R01: 3-bit instruction, 1-bit bypass, 32-bit ID register.
// R02: code 000 samples pins, scans ring, tristates outputs.
// R03: code 001 loads ID, scans it, memory untouched.
// R04: code 010 samples pins, scans ring, tristates drivers.
// R05: controller never loads reserved codes 011, 101, 110.
// R06: code 100 samples and scans ring, no preset.
// R07: code 111 scans bypass bit, memory untouched.
// R08: wide chain: seventy cells in fixed order.
// R09: narrow chain: fifty-one cells in fixed order.
// R10: identification instruction after power-up and reset state.
// R11: ID holds revision, depth, width, presence bit.
// R12: update-dr under sample acts like pause-dr.
// R13: standard sixteen-state controller, lsb-first shifting.
// R14: tristate released once other instruction loaded.
module sbstap_top
    import sbstap_pkg::*;
#(
    parameter int ORG_X36 = 1,
    parameter logic [3:0] REV_ID = 4'h0, // arbitrary value
    parameter logic [5:0] DEV_ID = 6'h00, // arbitrary value
    parameter logic [10:0] VENDOR_ID = 11'h155 // arbitrary value
)(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_n_o,
    output logic mem_out_hiz_o,
    output logic [IR_W-1:0] instr_o,
    input wire logic [ADDR_HI_N-1:0] addr_hi_i,
    input wire logic burst_addr_bit0_i,
    input wire logic burst_addr_bit1_i,
    input wire logic sleep_request_in_i,
    input wire logic burst_advance_in_i,
    input wire logic cpu_addr_strobe_in_i,
    input wire logic ctrl_addr_strobe_in_i,
    input wire logic out_enable_n_i,
    input wire logic byte_write_gate_n_i,
    input wire logic all_bytes_write_n_i,
    input wire logic sram_clk_i,
    input wire logic lane_a_write_n_i,
    input wire logic lane_b_write_n_i,
    input wire logic lane_c_write_n_i,
    input wire logic lane_d_write_n_i,
    input wire logic chip_enable_n_i,
    input wire logic burst_order_sel_i,
    input wire logic [LANE_W-1:0] data_lane_a_i,
    input wire logic [LANE_W-1:0] data_lane_b_i,
    input wire logic [LANE_W-1:0] data_lane_c_i,
    input wire logic [LANE_W-1:0] data_lane_d_i
);

    localparam int BSR_LEN = (ORG_X36 == 1) ? BSR_LEN_X36 : BSR_LEN_X18;

    localparam logic [ID_W-1:0] ID_VALUE =
        (ID_W'(REV_ID) << ID_REV_LSB) |
        (ID_W'(ID_DEPTH_CODE[ORG_X36]) << ID_DEPTH_LSB) |
        (ID_W'(ID_WIDTH_CODE[ORG_X36]) << ID_WIDTH_LSB) |
        (ID_W'(DEV_ID) << ID_DEV_LSB) |
        (ID_W'(VENDOR_ID) << ID_VEND_LSB) |
        (ID_W'(1) << ID_PRESENT_BIT); // R11

    if (ORG_X36 != 0 && ORG_X36 != 1) begin : g_bad_org
        $error("ORG_X36 must be 0 or 1");
    end

    // ---------------- pin ring assembly ----------------
    logic [DQ_N-1:0] dq_all;
    logic [CTL_N-1:0] ctl_all;
    logic [BSR_LEN-1:0] ring_pins;

    assign dq_all = {data_lane_d_i, data_lane_c_i, data_lane_b_i, data_lane_a_i};

    always_comb begin
        ctl_all = '0;
        ctl_all[CTL_SLEEP] = sleep_request_in_i;
        ctl_all[CTL_ADV] = burst_advance_in_i;
        ctl_all[CTL_CPU_ADDR_STROBE_IN] = cpu_addr_strobe_in_i;
        ctl_all[CTL_CTRL_ADDR_STROBE_IN] = ctrl_addr_strobe_in_i;
        ctl_all[CTL_OE] = out_enable_n_i;
        ctl_all[CTL_BWE] = byte_write_gate_n_i;
        ctl_all[CTL_GW] = all_bytes_write_n_i;
        ctl_all[CTL_CLK] = sram_clk_i;
        ctl_all[CTL_BWA] = lane_a_write_n_i;
        ctl_all[CTL_BWB] = lane_b_write_n_i;
        ctl_all[CTL_BWC] = lane_c_write_n_i;
        ctl_all[CTL_BWD] = lane_d_write_n_i;
        ctl_all[CTL_CE] = chip_enable_n_i;
        ctl_all[CTL_MODE] = burst_order_sel_i;
        ctl_all[CTL_A1] = burst_addr_bit1_i;
        ctl_all[CTL_A0] = burst_addr_bit0_i;
    end

    // cell n sits at ring bit n-1; the unconnected cell reads zero
    always_comb begin
        ring_pins = '0;
        for (int k = 0; k < ADDR_HI_N; k++) begin
            if (ADDR_CELLS[ORG_X36][k] != 0) begin
                ring_pins[ADDR_CELLS[ORG_X36][k] - 1] = addr_hi_i[k]; // R08 R09
            end
        end
        for (int k = 0; k < DQ_N; k++) begin
            if (DQ_CELLS[ORG_X36][k] != 0) begin
                ring_pins[DQ_CELLS[ORG_X36][k] - 1] = dq_all[k]; // R08 R09
            end
        end
        for (int k = 0; k < CTL_N; k++) begin
            if (CTL_CELLS[ORG_X36][k] != 0) begin
                ring_pins[CTL_CELLS[ORG_X36][k] - 1] = ctl_all[k]; // R08 R09
            end
        end
    end

    // ---------------- test clock domain ----------------
    logic rst_meta_r;
    logic tap_rstn_r;
    logic [BSR_LEN-1:0] pins_meta_r;
    logic [BSR_LEN-1:0] pins_sync_r;
    sbstap_state_t state;
    logic [IR_W-1:0] ir_r;
    logic [IR_W-1:0] ir_nxt;
    logic [IR_W-1:0] ir_sh_r;
    logic [BSR_LEN-1:0] bsr_sh_r;
    logic [ID_W-1:0] id_sh_r;
    logic [BYP_W-1:0] byp_r;
    logic hiz_tck_r;
    logic [IR_W-1:0] ir_hold_r;
    logic ir_tgl_r;
    logic tdo_r;
    logic tdo_oe_n_r;
    logic bsr_sel;
    logic id_sel;
    logic dr_out;

    always_ff @(posedge tck_i) begin
        rst_meta_r <= rstn_i;
        tap_rstn_r <= rst_meta_r;
    end

    // pins move on the memory clock; a capture may still catch a transition
    always_ff @(posedge tck_i) begin
        pins_meta_r <= ring_pins;
        pins_sync_r <= pins_meta_r;
    end

    sbstap_fsm u_fsm (
        .tck_i(tck_i),
        .tap_rstn_i(tap_rstn_r),
        .tms_i(tms_i),
        .state_o(state)
    );

    // the controller may stop the test clock in idle right after an
    // update, so the instruction register, the tristate flag and the hand-off take this value
    always_comb begin
        ir_nxt = ir_r;
        if (!tap_rstn_r || state == ST_TLR) begin
            ir_nxt = INS_IDCODE; // R10
        end else if (state == ST_UPD_IR) begin
            ir_nxt = ir_sh_r;
        end
    end

    always_ff @(posedge tck_i) begin
        ir_r <= ir_nxt;
        if (!tap_rstn_r || state == ST_TLR) begin
            ir_sh_r <= IR_CAPTURE;
        end else if (state == ST_CAP_IR) begin
            ir_sh_r <= IR_CAPTURE;
        end else if (state == ST_SH_IR) begin
            ir_sh_r <= {tdi_i, ir_sh_r[IR_W-1:1]}; // R01 R13
        end
    end

    // reserved codes fall through to the bypass path
    always_comb begin
        bsr_sel = 1'b0;
        id_sel = 1'b0;
        unique case (ir_r)
            INS_EXTEST, INS_SAMPLE_Z, INS_SAMPLE: bsr_sel = 1'b1; // R02 R04 R06
            INS_IDCODE: id_sel = 1'b1; // R03
            INS_BYPASS, INS_RSV_3, INS_RSV_5, INS_RSV_6: bsr_sel = 1'b0; // R05 R07
        endcase
    end

    // no preload stage: update-dr leaves the shifter as pause-dr would
    always_ff @(posedge tck_i) begin
        if (!tap_rstn_r) begin
            bsr_sh_r <= '0;
        end else if (bsr_sel) begin
            if (state == ST_CAP_DR) begin
                bsr_sh_r <= pins_sync_r; // R02 R04 R06
            end else if (state == ST_SH_DR) begin
                bsr_sh_r <= {tdi_i, bsr_sh_r[BSR_LEN-1:1]}; // R13
            end
        end
    end // R12

    always_ff @(posedge tck_i) begin
        if (!tap_rstn_r) begin
            id_sh_r <= '0;
        end else if (id_sel) begin
            if (state == ST_CAP_DR) begin
                id_sh_r <= ID_VALUE; // R03 R11
            end else if (state == ST_SH_DR) begin
                id_sh_r <= {tdi_i, id_sh_r[ID_W-1:1]}; // R01 R13
            end
        end
    end

    always_ff @(posedge tck_i) begin
        if (!tap_rstn_r) begin
            byp_r <= '0;
        end else if (!bsr_sel && !id_sel) begin
            if (state == ST_CAP_DR) begin
                byp_r <= '0;
            end else if (state == ST_SH_DR) begin
                byp_r <= tdi_i; // R01 R07
            end
        end
    end

    // tristate follows the loaded instruction only, never the scan state
    always_ff @(posedge tck_i) begin
        if (!tap_rstn_r) begin
            hiz_tck_r <= 1'b0;
        end else begin
            hiz_tck_r <= (ir_nxt == INS_EXTEST) || (ir_nxt == INS_SAMPLE_Z); // R02 R04 R14
        end
    end

    // instruction word handed to the memory clock by toggle; the word
    // holds for at least three test clocks, far longer than the crossing
    always_ff @(posedge tck_i) begin
        if (!tap_rstn_r) begin
            ir_hold_r <= INS_IDCODE;
            ir_tgl_r <= 1'b0;
        end else if (ir_hold_r != ir_nxt) begin
            ir_hold_r <= ir_nxt;
            ir_tgl_r <= ~ir_tgl_r;
        end
    end

    always_comb begin
        if (bsr_sel) begin
            dr_out = bsr_sh_r[0];
        end else if (id_sel) begin
            dr_out = id_sh_r[0];
        end else begin
            dr_out = byp_r[0];
        end
    end

    // serial output launched on the falling edge, driven only while shifting
    always_ff @(negedge tck_i) begin
        if (!tap_rstn_r) begin
            tdo_r <= 1'b0;
            tdo_oe_n_r <= 1'b1;
        end else begin
            tdo_oe_n_r <= !(state == ST_SH_IR || state == ST_SH_DR);
            tdo_r <= (state == ST_SH_IR) ? ir_sh_r[0] : dr_out; // R13
        end
    end

    assign tdo_o = tdo_r;
    assign tdo_oe_n_o = tdo_oe_n_r;

    // ---------------- memory clock domain ----------------
    logic hiz_meta_r;
    logic hiz_sync_r;
    logic tgl_meta_r;
    logic tgl_sync_r;
    logic tgl_seen_r;
    logic [IR_W-1:0] instr_r;

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            hiz_meta_r <= 1'b0;
            hiz_sync_r <= 1'b0;
        end else begin
            hiz_meta_r <= hiz_tck_r;
            hiz_sync_r <= hiz_meta_r; // R14
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            tgl_meta_r <= 1'b0;
            tgl_sync_r <= 1'b0;
            tgl_seen_r <= 1'b0;
        end else begin
            tgl_meta_r <= ir_tgl_r;
            tgl_sync_r <= tgl_meta_r;
            tgl_seen_r <= tgl_sync_r;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            instr_r <= INS_IDCODE;
        end else if (tgl_sync_r != tgl_seen_r) begin
            instr_r <= ir_hold_r;
        end
    end

    assign mem_out_hiz_o = hiz_sync_r;
    assign instr_o = instr_r;

endmodule

// ---- sbstap_top_assertions.sv ----
`timescale 1ns/1ps
module sbstap_top_chk
    import sbstap_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdo_oe_n_o,
    input wire logic mem_out_hiz_o,
    input wire logic [IR_W-1:0] instr_o
);
    logic no_hiz;
    // every code outside 000 and 010 leaves the memory outputs alone
    assign no_hiz = instr_o[0] | instr_o[2];

    chk_instr_reset: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        $rose(rstn_i) |-> instr_o == INS_IDCODE)
        else $error("instruction not identification after reset");
    chk_hiz_reset: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        $rose(rstn_i) |-> !mem_out_hiz_o)
        else $error("outputs still high-z after reset");
    // hiz leads the instruction status by one cycle, hence the exit window
    chk_hiz_extest: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (instr_o == INS_EXTEST) [*6] |-> mem_out_hiz_o or ##[1:8] (instr_o != INS_EXTEST))
        else $error("outputs not high-z under code 000");
    chk_hiz_samplez: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (instr_o == INS_SAMPLE_Z) [*6] |-> mem_out_hiz_o or ##[1:8] (instr_o != INS_SAMPLE_Z))
        else $error("outputs not high-z under code 010");
    chk_hiz_release: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        no_hiz [*6] |-> !mem_out_hiz_o or ##[1:8] !no_hiz)
        else $error("outputs high-z under a non-tristating code");
    chk_tlr_ident: assert property (@(posedge tck_i) disable iff (!rstn_i)
        tms_i [*5] |-> ##[1:4] instr_o == INS_IDCODE)
        else $error("identification not loaded by reset state");
    chk_oe_exit: assert property (@(posedge tck_i) disable iff (!rstn_i)
        $rose(tdo_oe_n_o) |-> $past(tms_i))
        else $error("serial output released without exit");
    chk_oe_enter: assert property (@(posedge tck_i) disable iff (!rstn_i)
        $fell(tdo_oe_n_o) |-> !$past(tms_i) && !$past(tms_i, 2))
        else $error("serial output enabled outside shift");

    cov_extest: cover property (@(posedge sys_clk_i) instr_o == INS_EXTEST && mem_out_hiz_o);
    cov_samplez: cover property (@(posedge sys_clk_i) instr_o == INS_SAMPLE_Z && mem_out_hiz_o);
    cov_tlr: cover property (@(posedge tck_i) tms_i [*5]);
endmodule

bind sbstap_top sbstap_top_chk chk_u (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .tck_i(tck_i),
    .tms_i(tms_i),
    .tdo_oe_n_o(tdo_oe_n_o),
    .mem_out_hiz_o(mem_out_hiz_o),
    .instr_o(instr_o)
);

// ---- sbstap_jtag_ctl.sv ----
`timescale 1ns/1ps
module sbstap_jtag_ctl (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i,
    input wire logic tdo_oe_n_i
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    // one test clock period; the clock stands still between calls
    task automatic pulse(input logic tms, input logic tdi, output logic [1:0] s);
        tms_o = tms;
        tdi_o = tdi;
        #80 s = {tdo_oe_n_i, tdo_i};
        tck_o = 1'b1;
        #80 tck_o = 1'b0;
    endtask

    // idle data line toggles so a stale value is never mistaken for data
    task automatic run(input int n, input logic tms);
        logic [1:0] s;
        #13;
        repeat (n) pulse(tms, ~tdi_o, s);
    endtask

    // from idle: capture, shift n bits lsb first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [71:0] din,
                        output logic [71:0] dout, output logic oe_bad);
        logic [1:0] s;
        dout = '0;
        oe_bad = 1'b0;
        #13;
        pulse(1'b1, ~tdi_o, s);
        if (ir) pulse(1'b1, ~tdi_o, s);
        pulse(1'b0, ~tdi_o, s);
        pulse(1'b0, ~tdi_o, s);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], s);
            dout[i] = s[0];
            oe_bad |= s[1];
        end
        pulse(1'b1, ~tdi_o, s);
        pulse(1'b0, ~tdi_o, s);
    endtask
endmodule

// ---- test_sbstap_top.sv ----
`timescale 1ns/1ps
module test_sbstap_top;
    import sbstap_pkg::*;
    localparam logic [3:0] TB_REV = 4'h0; // arbitrary value
    localparam logic [5:0] TB_DEV = 6'h00; // arbitrary value
    localparam logic [10:0] TB_VEND = 11'h2A6; // arbitrary value
    localparam logic [31:0] ID_EXP = {TB_REV, 5'h07, 5'h04, TB_DEV, TB_VEND, 1'b1};
    localparam logic [31:0] ID_EXP_N = {TB_REV, 5'h08, 5'h03, TB_DEV, TB_VEND, 1'b1};
    localparam logic [69:0] PAT = 70'h3A_5C96_E1B4_7D29_C6E3;
    localparam int CELL [25] = '{1, 2, 3, 4, 5, 6, 7, 8, 17, 18, 29, 30, 31, 32, 33, 34, 35,
        37, 40, 42, 45, 63, 64, 69, 70};
    localparam int SRC [25] = '{0, 1, 2, 3, 4, 5, 6, 34, 20, 43, 21, 22, 23, 24, 25, 26, 27,
        28, 31, 32, 52, 69, 33, 19, 18};
    localparam int CELL_N [22] = '{1, 2, 3, 4, 5, 6, 7, 8, 12, 17, 18, 21, 24, 27, 29, 30, 32,
        35, 45, 49, 50, 51};
    localparam int SRC_N [22] = '{0, 1, 2, 3, 4, 5, 6, 34, 20, 42, 7, 21, 24, 27, 28, 29, 32,
        43, 33, 17, 19, 18};
    logic sys_clk_i, rstn_i, tck, tms, tdi, tdo, tdo_oe_n, hiz, bad;
    logic narrow_sel, tdo_m, oe_m, n_tdo, n_oe_n, n_hiz;
    logic [2:0] instr;
    logic [2:0] n_instr;
    logic [69:0] pin_r;
    logic [71:0] q;
    int err_count = 0, cmp_count = 0, cyc = 0;

    sbstap_top #(.ORG_X36(1), .REV_ID(TB_REV), .DEV_ID(TB_DEV), .VENDOR_ID(TB_VEND)) uut (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .mem_out_hiz_o(hiz), .instr_o(instr),
        .addr_hi_i(pin_r[17:0]), .burst_addr_bit0_i(pin_r[18]), .burst_addr_bit1_i(pin_r[19]),
        .sleep_request_in_i(pin_r[20]), .burst_advance_in_i(pin_r[21]),
        .cpu_addr_strobe_in_i(pin_r[22]), .ctrl_addr_strobe_in_i(pin_r[23]),
        .out_enable_n_i(pin_r[24]), .byte_write_gate_n_i(pin_r[25]),
        .all_bytes_write_n_i(pin_r[26]), .sram_clk_i(pin_r[27]),
        .lane_a_write_n_i(pin_r[28]), .lane_b_write_n_i(pin_r[29]),
        .lane_c_write_n_i(pin_r[30]), .lane_d_write_n_i(pin_r[31]),
        .chip_enable_n_i(pin_r[32]), .burst_order_sel_i(pin_r[33]),
        .data_lane_a_i(pin_r[42:34]), .data_lane_b_i(pin_r[51:43]),
        .data_lane_c_i(pin_r[60:52]), .data_lane_d_i(pin_r[69:61])
    );
    // narrow organisation shares the link; only its serial output and output enable are muxed in
    sbstap_top #(.ORG_X36(0), .REV_ID(TB_REV), .DEV_ID(TB_DEV), .VENDOR_ID(TB_VEND)) uut_n (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .tdo_o(n_tdo), .tdo_oe_n_o(n_oe_n), .mem_out_hiz_o(n_hiz), .instr_o(n_instr),
        .addr_hi_i(pin_r[17:0]), .burst_addr_bit0_i(pin_r[18]), .burst_addr_bit1_i(pin_r[19]),
        .sleep_request_in_i(pin_r[20]), .burst_advance_in_i(pin_r[21]),
        .cpu_addr_strobe_in_i(pin_r[22]), .ctrl_addr_strobe_in_i(pin_r[23]),
        .out_enable_n_i(pin_r[24]), .byte_write_gate_n_i(pin_r[25]),
        .all_bytes_write_n_i(pin_r[26]), .sram_clk_i(pin_r[27]),
        .lane_a_write_n_i(pin_r[28]), .lane_b_write_n_i(pin_r[29]),
        .lane_c_write_n_i(pin_r[30]), .lane_d_write_n_i(pin_r[31]),
        .chip_enable_n_i(pin_r[32]), .burst_order_sel_i(pin_r[33]),
        .data_lane_a_i(pin_r[42:34]), .data_lane_b_i(pin_r[51:43]),
        .data_lane_c_i(pin_r[60:52]), .data_lane_d_i(pin_r[69:61])
    );
    assign tdo_m = narrow_sel ? n_tdo : tdo;
    assign oe_m = narrow_sel ? n_oe_n : tdo_oe_n;
    sbstap_jtag_ctl ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_m), .tdo_oe_n_i(oe_m));

    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // the test clock must run while reset is low, the tap reset is synchronous
    task automatic do_reset();
        @(posedge sys_clk_i);
        rstn_i <= 1'b0;
        ctl.run(6, 1'b1);
        @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        ctl.run(5, 1'b1);
        ctl.run(1, 1'b0);
    endtask

    task automatic load_ir(input logic [2:0] code);
        ctl.scan(1'b1, 3, 72'(code), q, bad);
        check("ir capture", 72'(q[2:0]), 72'h1);
        check("ir shift enable", 72'(bad), 72'h0);
        // status lags the update by one test clock plus a few system clocks
        repeat (12) @(posedge sys_clk_i);
    endtask

    task automatic test_reset();
        check("instr", 72'(instr), 72'(INS_IDCODE));
        check("hiz", 72'(hiz), 72'h0);
        check("tdo enable", 72'(tdo_oe_n), 72'h1);
        ctl.scan(1'b0, 32, '0, q, bad);
        check("idcode", 72'(q[31:0]), 72'(ID_EXP));
        $display("test_reset done");
    endtask

    task automatic test_codes();
        logic [2:0] codes [5] = '{INS_EXTEST, INS_SAMPLE_Z, INS_SAMPLE, INS_IDCODE, INS_BYPASS};
        int len;
        foreach (codes[k]) begin
            load_ir(codes[k]);
            len = (codes[k] == INS_BYPASS) ? 1 : (codes[k] == INS_IDCODE) ? ID_W : 70;
            check("instr", 72'(instr), 72'(codes[k]));
            check("hiz", 72'(hiz), 72'(codes[k] == INS_EXTEST || codes[k] == INS_SAMPLE_Z));
            ctl.scan(1'b0, len + 2, {36{2'b10}}, q, bad);
            check("chain end", 72'(q[len +: 2]), 72'h2);
            check("chain first", 72'(q[0]), 72'(codes[k] != INS_BYPASS));
        end
        $display("test_codes done");
    endtask

    task automatic test_bsr();
        load_ir(INS_SAMPLE);
        for (int p = 0; p < 2; p++) begin
            @(posedge sys_clk_i);
            pin_r <= p ? ~PAT : PAT;
            // pins pass two test clock flops before capture
            ctl.run(3, 1'b0);
            // shifted-in data passes update-dr and must not reach anything
            ctl.scan(1'b0, 70, {36{2'b10}}, q, bad);
            foreach (CELL[k]) check("cell", 72'(q[CELL[k] - 1]), 72'(pin_r[SRC[k]]));
            check("dr shift enable", 72'(bad), 72'h0);
            check("hiz", 72'(hiz), 72'h0);
            check("instr", 72'(instr), 72'(INS_SAMPLE));
        end
        $display("test_bsr done");
    endtask

    task automatic test_narrow();
        narrow_sel = 1'b1;
        load_ir(INS_SAMPLE);
        check("narrow instr", 72'(n_instr), 72'(INS_SAMPLE));
        ctl.scan(1'b0, 53, {36{2'b10}}, q, bad);
        foreach (CELL_N[k]) begin
            check("narrow cell", 72'(q[CELL_N[k] - 1]), 72'(pin_r[SRC_N[k]]));
        end
        check("narrow chain end", 72'(q[51 +: 2]), 72'h2);
        check("narrow shift enable", 72'(bad), 72'h0);
        check("narrow hiz", 72'(n_hiz), 72'h0);
        ctl.run(5, 1'b1);
        ctl.run(1, 1'b0);
        ctl.scan(1'b0, 32, '0, q, bad);
        check("narrow idcode", 72'(q[31:0]), 72'(ID_EXP_N));
        narrow_sel = 1'b0;
        $display("test_narrow done");
    endtask

    task automatic test_tlr();
        load_ir(INS_EXTEST);
        ctl.run(5, 1'b1);
        ctl.run(1, 1'b0);
        repeat (12) @(posedge sys_clk_i);
        check("instr", 72'(instr), 72'(INS_IDCODE));
        check("hiz", 72'(hiz), 72'h0);
        load_ir(INS_SAMPLE_Z);
        check("hiz", 72'(hiz), 72'h1);
        do_reset();
        repeat (12) @(posedge sys_clk_i);
        check("instr", 72'(instr), 72'(INS_IDCODE));
        check("hiz", 72'(hiz), 72'h0);
        $display("test_tlr done");
    endtask

    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end

    initial begin
        rstn_i = 1'b0;
        pin_r = PAT;
        narrow_sel = 1'b0;
        do_reset();
        test_reset();
        test_codes();
        test_bsr();
        test_narrow();
        test_tlr();
        finish_test();
    end
endmodule
